// ### lgm_params.svh
// Register offsets, field positions, reset values and timing counts of the pin mapper
`ifndef LGM_PARAMS_SVH
`define LGM_PARAMS_SVH

// ==========================================
// Register offsets
`define LGM_ADDR_PIN_STS 8'h0E
`define LGM_ADDR_IN_DIS 8'h0F
`define LGM_ADDR_PIN_CTL0 8'h10
`define LGM_ADDR_PIN_CTL7 8'h17
`define LGM_ADDR_BC_A 8'h6E
`define LGM_ADDR_BC_B 8'h6F
`define LGM_ADDR_PD_DIS 8'hBE

// ==========================================
// Pin output control fields
`define LGM_CTL_OE 0
`define LGM_CTL_VAL 1
`define LGM_CTL_SRC_LO 2
`define LGM_CTL_SRC_HI 3
`define LGM_CTL_SEL_LO 4
`define LGM_CTL_SEL_HI 7

// ==========================================
// Back-channel slot source codes
`define LGM_BC_SRC_FSYNC_INT 4'h8
`define LGM_BC_SRC_FSYNC_EXT 4'h9

// ==========================================
// Reset values
`define LGM_RST_PIN_CTL 8'h00
`define LGM_RST_IN_DIS 8'h00
`define LGM_RST_PD_DIS 8'h00
`define LGM_RST_BC_CTL 8'h00

// ==========================================
// Timing
`define LGM_CLK_MHZ 100
`define LGM_FC_LAT_NS 225
`define LGM_FC_LAT_CYC ((`LGM_FC_LAT_NS * `LGM_CLK_MHZ + 999) / 1000)
`define LGM_BC_FRAME_BITS 30
`define LGM_FC_INTERVAL_1 1
`define LGM_FC_INTERVAL_2 2
`define LGM_FC_INTERVAL_34 5

`endif

// ### lgm_pkg.sv
// Types shared by the pin mapper modules
package lgm_pkg;

	// ==========================================
	// Pin output source
	typedef enum logic [1:0] {
		LGM_SRC_REG = 2'h0,
		LGM_SRC_FWD = 2'h1,
		LGM_SRC_FSYNC = 2'h2,
		LGM_SRC_CTRL = 2'h3
	} lgm_src_t;

	// ==========================================
	// Forward sampler
	typedef enum logic [1:0] {
		LGM_FS_IDLE = 2'b01,
		LGM_FS_WAIT = 2'b10
	} lgm_fs_state_t;

	typedef struct packed {
		lgm_fs_state_t st;
		logic [2:0] frm;
		logic [3:0] pend;
		logic [4:0] dly;
		logic [3:0] val;
	} lgm_fs_st_t;

	// ==========================================
	// Main block state
	typedef struct packed {
		logic [7:0][7:0] pin_ctl;
		logic [7:0] in_dis;
		logic [7:0] pd_dis;
		logic [3:0][7:0] bc_a;
		logic [3:0][7:0] bc_b;
		logic [3:0][4:0] bc_bit;
		logic [3:0][3:0] bc_slot;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic [7:0] rdata;
	} lgm_main_st_t;

endpackage : lgm_pkg

// ### lgm_fwd_sampler.sv
// Forward-channel pin sampler for one receive port
`timescale 1ns/10ps
`include "lgm_params.svh"

module lgm_fwd_sampler (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Forward link
	input wire logic fwd_frame_in,
	input wire logic [3:0] fwd_pins_in,
	input wire logic [2:0] forward_linked_pin_count_in,
	input wire logic legacy_in,
	// Sampled values
	output logic [3:0] fwd_pins_out
);

	localparam int LAT_I = `LGM_FC_LAT_CYC;
	localparam logic [4:0] DLY_LOAD = 5'(`LGM_FC_LAT_CYC - 2);

	lgm_pkg::lgm_fs_st_t q;
	lgm_pkg::lgm_fs_st_t d;
	logic [2:0] interval_w;
	logic samp_w;

	// ==========================================
	// Sampling interval
	// RL4 interval from linked count
	always_comb begin
		unique case (forward_linked_pin_count_in)
			3'h1: interval_w = 3'(`LGM_FC_INTERVAL_1);
			3'h2: interval_w = 3'(`LGM_FC_INTERVAL_2);
			3'h3, 3'h4: interval_w = 3'(`LGM_FC_INTERVAL_34);
			default: interval_w = 3'h0;
		endcase
	end

	// RL18 older serializer sends no pins
	assign samp_w = fwd_frame_in && !legacy_in && (interval_w != 3'h0) && (q.frm >= interval_w - 3'h1);

	// ==========================================
	// State update
	always_comb begin
		d = q;
		if (fwd_frame_in) begin
			d.frm = samp_w ? 3'h0 : q.frm + 3'h1;
		end
		if (legacy_in) begin
			d.val = 4'h0;
		end
		// RL5 fixed latency after sample
		unique case (q.st)
			lgm_pkg::LGM_FS_IDLE: begin
				if (samp_w) begin
					d.pend = fwd_pins_in;
					d.dly = DLY_LOAD;
					d.st = lgm_pkg::LGM_FS_WAIT;
				end
			end
			lgm_pkg::LGM_FS_WAIT: begin
				// Late sample arriving before dly reaches zero joins the pending update rather than restarting it, so updates never starve
				if (samp_w) begin
					d.pend = fwd_pins_in;
				end
				if (q.dly == 5'h00) begin
					d.val = legacy_in ? 4'h0 : q.pend;
					d.st = lgm_pkg::LGM_FS_IDLE;
				end else begin
					d.dly = q.dly - 5'h01;
				end
			end
			default: d.st = lgm_pkg::LGM_FS_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			q <= '{st: lgm_pkg::LGM_FS_IDLE, frm: 3'h0, pend: 4'h0, dly: 5'h00, val: 4'h0};
		end else begin
			q <= d;
		end
	end

	assign fwd_pins_out = q.val;

	// ==========================================
	// Checks
	a_fwd_interval: assert property (@(posedge clk_in) disable iff (rst_in) // RL4
		samp_w |-> fwd_frame_in && (q.frm == interval_w - 3'h1 || q.frm > interval_w - 3'h1))
		else $error("forward sample off its frame interval");
	a_fwd_latency: assert property (@(posedge clk_in) disable iff (rst_in) // RL5
		(samp_w && q.st == lgm_pkg::LGM_FS_IDLE) |-> ##[LAT_I:LAT_I] (q.st == lgm_pkg::LGM_FS_IDLE))
		else $error("forward latency not met");
	a_fwd_apply: assert property (@(posedge clk_in) disable iff (rst_in) // RL2
		(q.st == lgm_pkg::LGM_FS_WAIT && q.dly == 5'h00 && !legacy_in) |=> fwd_pins_out == $past(q.pend))
		else $error("forward value not applied");
	a_fwd_legacy: assert property (@(posedge clk_in) disable iff (rst_in) // RL18
		legacy_in |=> fwd_pins_out == 4'h0)
		else $error("older serializer value leaked");
	c_fwd_sample: cover property (@(posedge clk_in) disable iff (rst_in) samp_w);

endmodule : lgm_fwd_sampler

// ### lgm_gpio_top.sv
// Pin unit: local pin control, forward-channel routing and back-channel slot sampling
// Behaviour
// RL1 - Software clears input enable, then sets control bit 0 for output.
// RL2 - Four forward pin values per receive port can drive local pins.
// RL3 - Any forward value from any port routes to any output pin.
// RL4 - Forward sample interval: one pin each frame, two every two, more every five.
// RL5 - Forward latency fixed near 225 ns regardless of linked count.
// RL6 - Forwarded signals should toggle below a quarter of sampling rate.
// RL7 - Any pin may output internal frame sync or internal control signals.
// RL8 - All pins are inputs after start-up.
// RL9 - Four back-channel slots per port, each sourced from any local pin.
// RL10 - One pin may feed many slots on any ports.
// RL11 - Back-channel slots sampled once per thirty-bit back-channel frame.
// RL12 - Back-channel latency and jitter about one back-channel frame.
// RL13 - Back-channel inputs should switch below a quarter of sampling rate.
// RL14 - Internal or external frame sync selectable per back-channel slot.
// RL15 - Slot configuration held per port in two control registers.
// RL16 - Status register returns present level of every pin.
// RL17 - Per-pin input disable and pulldown disable; both paths enabled after reset.
// RL18 - Older parallel serializer supplies no forward pin values.
// RL19 - Pin n maps to input-disable bit n; bit 0 not used.
// RL20 - Output pin without other source drives its control register value.
// RL21 - Each slot repeats its latest sample until replaced.
`timescale 1ns/10ps
`include "lgm_params.svh"

module lgm_gpio_top #(
	parameter int NUM_PORTS = 4,
	parameter int NUM_PINS = 8
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [1:0] reg_port_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Local pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out_out,
	output logic [7:0] pin_oe_out,
	output logic [7:0] pin_in_en_out,
	output logic [7:0] pin_pd_en_out,
	// Internal signals
	input wire logic frame_sync_signal_int_in,
	input wire logic frame_sync_signal_ext_in,
	input wire logic [7:0] int_ctrl_in,
	// Forward channel
	input wire logic [3:0] fwd_frame_in,
	input wire logic [15:0] fwd_pins_in,
	input wire logic [11:0] forward_linked_pin_count_in,
	input wire logic [3:0] legacy_ser_in,
	// Back channel
	input wire logic [3:0] bc_bit_en_in,
	output logic [15:0] bc_slot_out
);

	lgm_pkg::lgm_main_st_t q;
	lgm_pkg::lgm_main_st_t d;
	logic [15:0] fwd_val_w;
	logic [7:0] level_w;
	logic [7:0] pin_src_w;
	logic [15:0] slot_src_w;
	logic [3:0] bc_tick_w;
	logic ctl_hit_w;
	logic [2:0] ctl_idx_w;

	// ==========================================
	// Forward samplers
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_fwd
			// RL2 four values per port
			lgm_fwd_sampler u_fwd (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.fwd_frame_in(fwd_frame_in[gp]),
				.fwd_pins_in(fwd_pins_in[gp*4 +: 4]),
				.forward_linked_pin_count_in(forward_linked_pin_count_in[gp*3 +: 3]),
				.legacy_in(legacy_ser_in[gp]),
				.fwd_pins_out(fwd_val_w[gp*4 +: 4])
			);
		end
	endgenerate

	// ==========================================
	// Pin levels and output sources
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			// RL16 level whether input or output
			assign level_w[gi] = q.pin_oe[gi] ? q.pin_out[gi] : pin_in[gi];
			// RL3 any forward value to any pin
			always_comb begin
				unique case (lgm_pkg::lgm_src_t'(q.pin_ctl[gi][`LGM_CTL_SRC_HI:`LGM_CTL_SRC_LO]))
					lgm_pkg::LGM_SRC_FWD: pin_src_w[gi] = fwd_val_w[q.pin_ctl[gi][`LGM_CTL_SEL_HI:`LGM_CTL_SEL_LO]];
					// RL7 frame sync or control out
					lgm_pkg::LGM_SRC_FSYNC: pin_src_w[gi] = frame_sync_signal_int_in;
					lgm_pkg::LGM_SRC_CTRL: pin_src_w[gi] = int_ctrl_in[q.pin_ctl[gi][`LGM_CTL_SEL_HI-1:`LGM_CTL_SEL_LO]];
					// RL20 register value
					default: pin_src_w[gi] = q.pin_ctl[gi][`LGM_CTL_VAL];
				endcase
			end
		end
	endgenerate

	// ==========================================
	// Back-channel slot sources
	genvar gs;
	generate
		for (gs = 0; gs < NUM_PORTS*4; gs++) begin : g_slot
			logic [3:0] code_w;
			assign code_w = (gs % 4 < 2) ? q.bc_a[gs/4][(gs%2)*4 +: 4] : q.bc_b[gs/4][(gs%2)*4 +: 4];
			// RL9 any pin per slot
			// RL10 shared pin allowed
			// RL14 frame sync sources
			always_comb begin
				if (code_w < 4'h8) begin
					slot_src_w[gs] = level_w[code_w[2:0]];
				end else if (code_w == `LGM_BC_SRC_FSYNC_INT) begin
					slot_src_w[gs] = frame_sync_signal_int_in;
				end else if (code_w == `LGM_BC_SRC_FSYNC_EXT) begin
					slot_src_w[gs] = frame_sync_signal_ext_in;
				end else begin
					slot_src_w[gs] = 1'b0;
				end
			end
		end
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_tick
			// RL11 one sample per frame start
			assign bc_tick_w[gp] = bc_bit_en_in[gp] && (q.bc_bit[gp] == 5'h00);
		end
	endgenerate

	assign ctl_hit_w = (reg_addr_in >= `LGM_ADDR_PIN_CTL0) && (reg_addr_in <= `LGM_ADDR_PIN_CTL7);
	assign ctl_idx_w = 3'(reg_addr_in - `LGM_ADDR_PIN_CTL0);

	// ==========================================
	// Next state
	always_comb begin
		d = q;
		// Registered pin drive keeps the pads glitch-free while the source mux changes
		for (int i = 0; i < NUM_PINS; i++) begin
			d.pin_oe[i] = q.pin_ctl[i][`LGM_CTL_OE];
			d.pin_out[i] = pin_src_w[i];
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (bc_bit_en_in[p]) begin
				d.bc_bit[p] = (q.bc_bit[p] == 5'(`LGM_BC_FRAME_BITS - 1)) ? 5'h00 : q.bc_bit[p] + 5'h01;
			end
			// RL21 held until next sample
			// RL12 one frame of latency
			if (bc_tick_w[p]) begin
				d.bc_slot[p] = slot_src_w[p*4 +: 4];
			end
		end
		if (reg_wr_in) begin
			if (ctl_hit_w) begin
				// RL1 output enable bit
				d.pin_ctl[ctl_idx_w] = reg_wdata_in;
			end
			unique case (reg_addr_in)
				// RL19 bit 0 unused
				`LGM_ADDR_IN_DIS: d.in_dis = {reg_wdata_in[7:1], 1'b0};
				`LGM_ADDR_PD_DIS: d.pd_dis = reg_wdata_in;
				// RL15 per-port slot registers
				`LGM_ADDR_BC_A: d.bc_a[reg_port_in] = reg_wdata_in;
				`LGM_ADDR_BC_B: d.bc_b[reg_port_in] = reg_wdata_in;
				default: d.in_dis = d.in_dis;
			endcase
		end
		if (reg_rd_in) begin
			d.rdata = 8'h00;
			if (ctl_hit_w) begin
				d.rdata = q.pin_ctl[ctl_idx_w];
			end
			unique case (reg_addr_in)
				// RL16 live levels
				`LGM_ADDR_PIN_STS: d.rdata = level_w;
				`LGM_ADDR_IN_DIS: d.rdata = q.in_dis;
				`LGM_ADDR_PD_DIS: d.rdata = q.pd_dis;
				`LGM_ADDR_BC_A: d.rdata = q.bc_a[reg_port_in];
				`LGM_ADDR_BC_B: d.rdata = q.bc_b[reg_port_in];
				default: d.rdata = d.rdata;
			endcase
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			// RL8 all pins inputs
			// RL17 input and pulldown enabled
			q <= '{pin_ctl: {8{`LGM_RST_PIN_CTL}}, in_dis: `LGM_RST_IN_DIS, pd_dis: `LGM_RST_PD_DIS,
				bc_a: {4{`LGM_RST_BC_CTL}}, bc_b: {4{`LGM_RST_BC_CTL}}, bc_bit: '0, bc_slot: '0,
				pin_out: 8'h00, pin_oe: 8'h00, rdata: 8'h00};
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata_out = q.rdata;
	assign pin_out_out = q.pin_out;
	assign pin_oe_out = q.pin_oe;
	// RL17 input and pulldown controls
	assign pin_in_en_out = ~q.in_dis;
	assign pin_pd_en_out = ~q.pd_dis;
	assign bc_slot_out = q.bc_slot;

	// ==========================================
	// Checks
	a_reset_inputs: assert property (@(posedge clk_in) disable iff (rst_in) // RL8
		$fell(rst_in) |-> (pin_oe_out == 8'h00) && (pin_pd_en_out == 8'hFF) && (pin_in_en_out == 8'hFF))
		else $error("pins not inputs after reset");
	a_oe_follow: assert property (@(posedge clk_in) disable iff (rst_in) // RL1
		(reg_wr_in && reg_addr_in == 8'h11) |=> ##1 pin_oe_out[1] == $past(reg_wdata_in[0], 2))
		else $error("output enable not taken from control");
	a_fwd_route: assert property (@(posedge clk_in) disable iff (rst_in) // RL3
		(q.pin_ctl[1][3:2] == 2'h1) |=> pin_out_out[1] == $past(fwd_val_w[q.pin_ctl[1][7:4]]))
		else $error("forward value not routed");
	a_fsync_out: assert property (@(posedge clk_in) disable iff (rst_in) // RL7
		(q.pin_ctl[2][3:2] == 2'h2) |=> pin_out_out[2] == $past(frame_sync_signal_int_in))
		else $error("frame sync not driven");
	a_reg_value: assert property (@(posedge clk_in) disable iff (rst_in) // RL20
		(q.pin_ctl[1][3:2] == 2'h0) |=> pin_out_out[1] == $past(q.pin_ctl[1][1]))
		else $error("register value not driven");
	a_status_level: assert property (@(posedge clk_in) disable iff (rst_in) // RL16
		(reg_rd_in && reg_addr_in == `LGM_ADDR_PIN_STS) |=> reg_rdata_out == $past(level_w))
		else $error("status level wrong");
	a_bc_sample: assert property (@(posedge clk_in) disable iff (rst_in) // RL11
		bc_tick_w[0] |=> bc_slot_out[3:0] == $past(slot_src_w[3:0]))
		else $error("slot not sampled at frame start");
	a_bc_hold: assert property (@(posedge clk_in) disable iff (rst_in) // RL21
		!bc_tick_w[0] |=> $stable(bc_slot_out[3:0]))
		else $error("slot changed between frames");
	a_bc_period: assert property (@(posedge clk_in) disable iff (rst_in) // RL12
		(bc_bit_en_in[0] && q.bc_bit[0] == 5'(`LGM_BC_FRAME_BITS - 1)) |=> q.bc_bit[0] == 5'h00)
		else $error("back-channel frame length wrong");
	a_pin0_input: assert property (@(posedge clk_in) disable iff (rst_in) // RL19
		pin_in_en_out[0])
		else $error("pin 0 input disabled");
	c_fwd_out: cover property (@(posedge clk_in) disable iff (rst_in) pin_oe_out[1] && q.pin_ctl[1][3:2] == 2'h1);
	c_bc_fsync: cover property (@(posedge clk_in) disable iff (rst_in) bc_tick_w[1] && q.bc_a[1][3:0] == 4'h9);
	c_status_rd: cover property (@(posedge clk_in) disable iff (rst_in) reg_rd_in && reg_addr_in == 8'h0E);

endmodule : lgm_gpio_top

// ### lgm_remote_ser_model.sv
// Remote serializer model: forward frames, forward pin values and back-channel bit pulses
`timescale 1ns/10ps

module lgm_remote_ser_model #(
	parameter int FRAME_CYC = 30
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Control from the bench
	input wire logic run_in,
	input wire logic [3:0] fix_in,
	input wire logic [2:0] count_in,
	input wire logic legacy_in,
	// Toward the pin unit
	output logic [3:0] fwd_frame_out,
	output logic [15:0] fwd_pins_out,
	output logic [11:0] count_out,
	output logic [3:0] legacy_out,
	output logic [3:0] bc_bit_en_out
);
	int cyc;
	logic [3:0] val;
	logic bc_ph;

	assign legacy_out = {1'b0, legacy_in, 2'h0};
	// linked count on port 2 only
	assign count_out = {3'h0, count_in, 6'h00};
	// counting mode breaks the slow-toggle advice on purpose
	assign fwd_pins_out = run_in ? {4{val}} : {4{fix_in}};

	// ==========================================
	// Frame pacing
	// one frame pulse per frame period
	always @(posedge clk_in) begin
		if (rst_in) begin
			cyc <= 0;
			val <= 4'h0;
			bc_ph <= 1'b0;
			fwd_frame_out <= 4'h0;
			bc_bit_en_out <= 4'h0;
		end else begin
			cyc <= (cyc + 1) % FRAME_CYC;
			fwd_frame_out <= {4{cyc == FRAME_CYC - 1}};
			if (cyc == 1) begin
				val <= val + 4'h1;
			end
			bc_ph <= ~bc_ph;
			bc_bit_en_out <= {4{bc_ph}};
		end
	end
endmodule : lgm_remote_ser_model

// ### testbench.sv
// Self-checking bench for the pin mapper
`timescale 1ns/10ps

module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [1:0] reg_port = 2'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pin_in_en;
	logic [7:0] pin_pd_en;
	logic fs_int = 1'b0;
	logic fs_ext = 1'b0;
	logic [7:0] int_ctrl = 8'h00;
	logic [3:0] fwd_frame;
	logic [15:0] fwd_pins;
	logic [11:0] lk_cnt;
	logic [3:0] legacy;
	logic [3:0] bc_bit_en;
	logic [15:0] bc_slot;
	logic run = 1'b0;
	logic [3:0] fix = 4'h0;
	logic [2:0] cnt = 3'h1;
	logic leg = 1'b0;
	logic [23:0] obs;
	logic [7:0] reset_addrs [7] = '{8'h0F, 8'h10, 8'h17, 8'h6E, 8'h6F, 8'hBE, 8'h55};
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc_n;

	assign obs = {bc_slot, pin_out};
	always #5 clk_in = ~clk_in;

	lgm_gpio_top uut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_port_in(reg_port),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
		.pin_in(pin_in), .pin_out_out(pin_out), .pin_oe_out(pin_oe), .pin_in_en_out(pin_in_en),
		.pin_pd_en_out(pin_pd_en), .frame_sync_signal_int_in(fs_int), .frame_sync_signal_ext_in(fs_ext),
		.int_ctrl_in(int_ctrl), .fwd_frame_in(fwd_frame), .fwd_pins_in(fwd_pins),
		.forward_linked_pin_count_in(lk_cnt), .legacy_ser_in(legacy), .bc_bit_en_in(bc_bit_en),
		.bc_slot_out(bc_slot));

	lgm_remote_ser_model #(.FRAME_CYC(30)) peer (.clk_in(clk_in), .rst_in(rst_in), .run_in(run),
		.fix_in(fix), .count_in(cnt), .legacy_in(leg), .fwd_frame_out(fwd_frame), .fwd_pins_out(fwd_pins),
		.count_out(lk_cnt), .legacy_out(legacy), .bc_bit_en_out(bc_bit_en));

	// ==========================================
	// Tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [1:0] p, input logic [7:0] d);
		@(negedge clk_in);
		reg_addr = a;
		reg_port = p;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_in);
		reg_wr = 1'b0;
	endtask : wr

	// Read data holds until the next read, so it is taken one full cycle late
	task automatic rdc(input logic [7:0] a, input logic [1:0] p, input logic [7:0] e);
		@(negedge clk_in);
		reg_addr = a;
		reg_port = p;
		reg_rd = 1'b1;
		@(negedge clk_in);
		reg_rd = 1'b0;
		@(negedge clk_in);
		chk(16'(reg_rdata), 16'(e));
	endtask : rdc

	task automatic wait_chg(input int k, input int lim, output int n);
		logic v;
		v = obs[k];
		n = 0;
		while (obs[k] === v) begin
			@(negedge clk_in);
			n++;
			if (n > lim) begin
				n_mismatch++;
				conclude();
			end
		end
	endtask : wait_chg

	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		chk(16'(pin_oe), 16'h0000);
		chk(16'({pin_in_en, pin_pd_en}), 16'hFFFF);
		for (int i = 0; i < 7; i++) rdc(reset_addrs[i], 2'h0, 8'h00);
		$display("test reset done");

		pin_in = 8'hA5;
		rdc(8'h0E, 2'h0, 8'hA5);
		wr(8'h0F, 2'h0, 8'h17);
		rdc(8'h0F, 2'h0, 8'h16);
		wr(8'hBE, 2'h0, 8'h3C);
		repeat (2) @(negedge clk_in);
		chk(16'({pin_in_en, pin_pd_en}), 16'hE9C3);
		wr(8'h11, 2'h0, 8'h03);
		repeat (3) @(negedge clk_in);
		chk(16'({pin_oe, pin_out[1]}), 16'h0005);
		rdc(8'h0E, 2'h0, 8'hA7);
		wr(8'h11, 2'h0, 8'h01);
		rdc(8'h0E, 2'h0, 8'hA5);
		$display("test pins done");

		wr(8'h12, 2'h0, 8'h09);
		wr(8'h14, 2'h0, 8'h5D);
		fs_int = 1'b1;
		int_ctrl = 8'h20;
		repeat (3) @(negedge clk_in);
		chk(16'({pin_out[4], pin_out[2]}), 16'h0003);
		fs_int = 1'b0;
		int_ctrl = 8'hDF;
		repeat (3) @(negedge clk_in);
		chk(16'({pin_out[4], pin_out[2]}), 16'h0000);
		$display("test internal done");

		wr(8'h11, 2'h0, 8'h85);
		repeat (70) @(negedge clk_in);
		chk(16'(pin_out[1]), 16'h0000);
		for (int i = 0; i < 40 && fwd_frame[2] !== 1'b1; i++) @(negedge clk_in);
		chk(16'(fwd_frame[2]), 16'h0001);
		fix = 4'hF;
		wait_chg(1, 60, cyc_n);
		chk(16'(cyc_n >= 24 && cyc_n <= 26), 16'h0001);
		leg = 1'b1;
		repeat (70) @(negedge clk_in);
		chk(16'(pin_out[1]), 16'h0000);
		leg = 1'b0;
		repeat (70) @(negedge clk_in);
		chk(16'(pin_out[1]), 16'h0001);
		cnt = 3'h0;
		fix = 4'h0;
		repeat (70) @(negedge clk_in);
		chk(16'(pin_out[1]), 16'h0001);
		// The counting source forces an output flip on every applied sample
		run = 1'b1;
		for (int i = 0; i < 4; i++) begin
			cnt = 3'(i + 1);
			wr(8'h11, 2'h0, i == 1 ? 8'h95 : 8'h85);
			repeat (3) wait_chg(1, 400, cyc_n);
			chk(16'(cyc_n), i == 0 ? 16'h001E : i == 1 ? 16'h003C : 16'h0096);
		end
		$display("test forward done");

		wr(8'h6E, 2'h1, 8'h83);
		wr(8'h6F, 2'h1, 8'h39);
		wr(8'h6E, 2'h0, 8'h03);
		rdc(8'h6E, 2'h1, 8'h83);
		rdc(8'h6F, 2'h1, 8'h39);
		rdc(8'h6E, 2'h0, 8'h03);
		pin_in[3] = 1'b1;
		fs_int = 1'b1;
		fs_ext = 1'b1;
		repeat (130) @(negedge clk_in);
		chk(16'({bc_slot[7:4], bc_slot[0]}), 16'h001F);
		pin_in[3] = 1'b0;
		fs_int = 1'b0;
		fs_ext = 1'b0;
		wait_chg(12, 70, cyc_n);
		chk(16'({bc_slot[7:4], bc_slot[0]}), 16'h0000);
		pin_in[3] = 1'b1;
		wait_chg(12, 70, cyc_n);
		chk(16'(cyc_n), 16'h003C);
		$display("test back channel done");
		conclude();
	end
endmodule : testbench
